/* design/aacr_map.vh */
`ifndef AACR_MAP_VH
`define AACR_MAP_VH
// ------------------------------
// Register offsets
// ------------------------------
`define AACR_OFS_OFFSET_LOOP_CONTROL 8'hcf
`define AACR_OFS_SLOW_RATE_CHAN_B_CTRL 8'hdb
`define AACR_OFS_SHAPING_PIN_OVERRIDE 8'hea
`define AACR_OFS_SLOW_RATE_SOURCE_SELECT 8'hef
`define AACR_OFS_OUTPUT_SWING_ENABLE 8'hf1
`define AACR_OFS_SLOW_RATE_CHAN_A_CTRL 8'hf2
`define AACR_OFS_OFFSET_LOOP_ON 8'h3d
// ------------------------------
// Field positions
// ------------------------------
`define AACR_BIT_HOLD 7
`define AACR_BIT_LOOP_ON 5
`define AACR_PERIOD_HI 5
`define AACR_PERIOD_LO 2
`define AACR_BIT_CHAN_B 0
`define AACR_BIT_CHAN_A 3
`define AACR_BIT_SRC_SEL 4
`define AACR_BIT_OVERRIDE 7
`define AACR_SWING_HI 1
`define AACR_SWING_LO 0
// ------------------------------
// Reset values and codes
// ------------------------------
`define AACR_RST_VAL 8'h00
`define AACR_SWING_ON 2'h3
`define AACR_SWING_OFF 2'h0
`define AACR_DATA_W 11
`endif

/* design/aacr_offset_loop.v */
`timescale 1ns/10ps
// ------------------------------
// Offset estimate and correction
// ------------------------------
module aacr_offset_loop (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire hold_i,
  input wire [3:0] period_i,
  input wire [10:0] sample_i,
  output reg [10:0] corrected_o,
  output reg [10:0] estimate_o
);
  reg [15:0] tick_r;
  reg [15:0] tick_nxt;
  reg [10:0] est_nxt;
  reg [10:0] mid;
  always @* begin
    mid = 11'h400;
    tick_nxt = tick_r + 16'h0001;
    est_nxt = estimate_o;
    if (!enable_i || hold_i) begin
      tick_nxt = tick_r;
    end else if (tick_r >= ((16'h0001 << period_i) - 16'h0001)) begin
      tick_nxt = 16'h0000;
      if (sample_i > (mid + estimate_o))
        est_nxt = estimate_o + 11'h001;
      else if (sample_i < (mid + estimate_o))
        est_nxt = estimate_o - 11'h001;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_r <= 16'h0000;
      estimate_o <= 11'h000;
      corrected_o <= 11'h000;
    end else begin
      tick_r <= tick_nxt;
      estimate_o <= est_nxt;
      if (enable_i)
        corrected_o <= sample_i - estimate_o;
      else
        corrected_o <= sample_i;
    end
  end
endmodule

/* design/aacr_regs.v */
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "aacr_map.vh"
// Function
// [R1] Hold bit stops estimate updates; last estimate still applied every cycle
// [R2] Hold clear lets estimate update; both act only with loop enable set
// [R3] Bits 5:2 set loop period in sample clock cycles
// [R4] Source select 0 follows clock pin level; 1 follows register bits
// [R5] Channel B slow-rate bit effective only under register control
// [R6] Channel A slow-rate bit effective only under register control
// [R7] Software sets source select before programming channel bits
// [R8] Swing field 11 enables register swing control, 00 disables; 01/10 illegal
// [R9] Software writes zero to reserved bits
// [R10] All registers reset to 00h
// [R11] Separate loop enable bit 5 turns offset correction on
// [R12] Override bit makes shaping selection come from registers
module aacr_regs (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire sclk_level_i,
  input wire [10:0] sample_i,
  output reg [7:0] rdata_o,
  output reg slow_rate_chan_a_o,
  output reg slow_rate_chan_b_o,
  output reg shaping_pin_override_o,
  output reg swing_reg_ctrl_o,
  output reg [10:0] corrected_o
);
  reg [7:0] loop_ctrl_r;
  reg [7:0] loop_on_r;
  reg [7:0] chan_b_r;
  reg [7:0] override_r;
  reg [7:0] src_sel_r;
  reg [7:0] swing_r;
  reg [7:0] chan_a_r;
  reg sclk_s1_r;
  reg sclk_s2_r;
  reg [7:0] rd_nxt;
  wire [10:0] corr_w;
  wire slow_a_w;
  wire slow_b_w;
  // ------------------------------
  // Pin synchroniser
  // ------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= sclk_level_i;
      sclk_s2_r <= sclk_s1_r;
    end
  end
  // ------------------------------
  // Register writes
  // ------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      loop_ctrl_r <= `AACR_RST_VAL; // [R10]
      loop_on_r <= `AACR_RST_VAL;
      chan_b_r <= `AACR_RST_VAL;
      override_r <= `AACR_RST_VAL;
      src_sel_r <= `AACR_RST_VAL;
      swing_r <= `AACR_RST_VAL;
      chan_a_r <= `AACR_RST_VAL;
    end else if (wr_i) begin
      case (addr_i)
        `AACR_OFS_OFFSET_LOOP_CONTROL: loop_ctrl_r <= wdata_i;
        `AACR_OFS_OFFSET_LOOP_ON: loop_on_r <= wdata_i;
        `AACR_OFS_SLOW_RATE_CHAN_B_CTRL: chan_b_r <= wdata_i;
        `AACR_OFS_SHAPING_PIN_OVERRIDE: override_r <= wdata_i;
        `AACR_OFS_SLOW_RATE_SOURCE_SELECT: src_sel_r <= wdata_i;
        `AACR_OFS_OUTPUT_SWING_ENABLE: swing_r <= wdata_i;
        `AACR_OFS_SLOW_RATE_CHAN_A_CTRL: chan_a_r <= wdata_i;
        default: begin
        end
      endcase
    end
  end
  // ------------------------------
  // Read path
  // ------------------------------
  always @* begin
    case (addr_i)
      `AACR_OFS_OFFSET_LOOP_CONTROL: rd_nxt = loop_ctrl_r;
      `AACR_OFS_OFFSET_LOOP_ON: rd_nxt = loop_on_r;
      `AACR_OFS_SLOW_RATE_CHAN_B_CTRL: rd_nxt = chan_b_r;
      `AACR_OFS_SHAPING_PIN_OVERRIDE: rd_nxt = override_r;
      `AACR_OFS_SLOW_RATE_SOURCE_SELECT: rd_nxt = src_sel_r;
      `AACR_OFS_OUTPUT_SWING_ENABLE: rd_nxt = swing_r;
      `AACR_OFS_SLOW_RATE_CHAN_A_CTRL: rd_nxt = chan_a_r;
      default: rd_nxt = 8'h00;
    endcase
  end
  // ------------------------------
  // Slow-rate source mux
  // ------------------------------
  assign slow_b_w = src_sel_r[`AACR_BIT_SRC_SEL] ? chan_b_r[`AACR_BIT_CHAN_B] : sclk_s2_r; // [R4] [R5]
  assign slow_a_w = src_sel_r[`AACR_BIT_SRC_SEL] ? chan_a_r[`AACR_BIT_CHAN_A] : sclk_s2_r; // [R4] [R6]
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      slow_rate_chan_a_o <= 1'b0;
      slow_rate_chan_b_o <= 1'b0;
      shaping_pin_override_o <= 1'b0;
      swing_reg_ctrl_o <= 1'b0;
      corrected_o <= 11'h000;
    end else begin
      rdata_o <= rd_i ? rd_nxt : 8'h00;
      slow_rate_chan_a_o <= slow_a_w;
      slow_rate_chan_b_o <= slow_b_w;
      shaping_pin_override_o <= override_r[`AACR_BIT_OVERRIDE]; // [R12]
      swing_reg_ctrl_o <= (swing_r[`AACR_SWING_HI:`AACR_SWING_LO] == `AACR_SWING_ON); // [R8]
      corrected_o <= corr_w;
    end
  end
  // ------------------------------
  // Offset loop
  // ------------------------------
  aacr_offset_loop u_loop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(loop_on_r[`AACR_BIT_LOOP_ON]), // [R11] [R2]
    .hold_i(loop_ctrl_r[`AACR_BIT_HOLD]), // [R1]
    .period_i(loop_ctrl_r[`AACR_PERIOD_HI:`AACR_PERIOD_LO]), // [R3]
    .sample_i(sample_i),
    .corrected_o(corr_w),
    .estimate_o()
  );
endmodule

/* tb/aacr_regs_properties.sv */
`timescale 1ns/10ps
module aacr_regs_properties (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire sclk_level_i,
  input wire [10:0] sample_i,
  input wire [7:0] rdata_o,
  input wire slow_rate_chan_a_o,
  input wire slow_rate_chan_b_o,
  input wire shaping_pin_override_o,
  input wire swing_reg_ctrl_o,
  input wire [10:0] corrected_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [23:0] s_q;
  wire w = wr_i;
  always @(posedge clk_i)
    if (rst_i) s_q <= 24'h00_0000;
    else if (w && addr_i == 8'hcf) s_q[7:0] <= wdata_i;
    else if (w && addr_i == 8'hef) s_q[15:8] <= wdata_i;
    else if (w && addr_i == 8'h3d) s_q[23:16] <= wdata_i;
  sequence reg_mode(a);
    w && addr_i == a ##1 s_q[12];
  endsequence
  chk_reset_clear: assert property ($fell(rst_i) |-> !(|{rdata_o, corrected_o, swing_reg_ctrl_o}))
    else $error("reset");
  chk_override_bit: assert property (w && addr_i == 8'hea |-> ##2
    shaping_pin_override_o == $past(wdata_i[7], 2)) else $error("override");
  chk_swing_code: assert property (w && addr_i == 8'hf1 |-> ##2
    swing_reg_ctrl_o == ($past(wdata_i[1:0], 2) == 2'h3)) else $error("swing");
  chk_chan_a_reg: assert property (reg_mode(8'hf2) |-> ##1
    slow_rate_chan_a_o == $past(wdata_i[3], 2)) else $error("chan a");
  chk_chan_b_reg: assert property (reg_mode(8'hdb) |-> ##1
    slow_rate_chan_b_o == $past(wdata_i[0], 2)) else $error("chan b");
  chk_pin_source: assert property ((!s_q[12] && $stable(sclk_level_i)) [*5] |->
    slow_rate_chan_a_o == sclk_level_i && slow_rate_chan_b_o == sclk_level_i) else $error("pin");
  chk_loop_bypass: assert property ((!s_q[21] && $stable(sample_i)) [*4] |->
    corrected_o == sample_i) else $error("bypass");
  chk_hold_frozen: assert property ((s_q[7] && s_q[21] && $stable(sample_i)) [*6] |->
    $stable(corrected_o)) else $error("hold");
endmodule
bind aacr_regs aacr_regs_properties chk_u (.*);

/* tb/adc_aux_config_registers_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("wrong value %0t %h %h", $time, a, e); end end
module adc_aux_config_registers_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sclk_level_i = 1'b0, ca, cb, ov, sw;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
  logic [10:0] sample_i = 11'h000, corrected_o, q;
  logic [7:0] ofs [6] = '{8'hcf, 8'hdb, 8'hea, 8'hef, 8'hf1, 8'hf2}, sh [6] = '{6{8'h00}};
  logic [7:0] msk [6] = '{8'hbc, 8'h01, 8'h80, 8'h10, 8'h03, 8'h08};
  int fail_count = 0, num_checks = 0, cyc = 0, n, k;
  aacr_regs dut_u (.*, .slow_rate_chan_a_o(ca), .slow_rate_chan_b_o(cb), .shaping_pin_override_o(ov),
    .swing_reg_ctrl_o(sw));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (cyc++ > 2000) begin
    fail_count++;
    give_verdict();
  end
  task give_verdict();
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task bus(input logic w, r, input logic [7:0] a, d);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, r, a, d};
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, e);
    bus(1'b0, 1'b1, a, 8'h00);
    {wr_i, rd_i} <= 2'b00;
    @(negedge clk_i);
    `CHK(rdata_o, e)
    @(posedge clk_i);
  endtask
  task period(input logic [7:0] d, input int e);
    bus(1'b1, 1'b0, 8'hcf, d);
    bus(1'b0, 1'b0, 8'hcf, d);
    repeat (4) @(posedge clk_i);
    k = 0;
    repeat (64) begin
      q = corrected_o;
      @(posedge clk_i);
      k += (corrected_o !== q);
    end
    `CHK(k >= e - 2 && k <= e + 2, 1'b1)
  endtask
  initial begin
    n = $urandom(73962);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({ca, cb, ov, sw, corrected_o}, 15'h0000)
    for (k = 0; k < 6; k++) rd(ofs[k], 8'h00);
    rd(8'h00, 8'h00);
    repeat (40) begin
      n = $urandom % 6;
      v = 8'($urandom) & msk[n];
      if (n == 4) v[1] = v[0];
      if ((n == 1 || n == 5) && !sh[3][4]) v = 8'h00;
      sh[n] = v;
      {sclk_level_i, sample_i} <= 12'($urandom);
      bus(1'b1, 1'b0, ofs[n], v);
      rd(ofs[n], v);
      repeat (2) @(posedge clk_i);
      `CHK({ca, cb}, sh[3][4] ? {sh[5][3], sh[1][0]} : {2{sclk_level_i}})
      `CHK({ov, sw, corrected_o}, {sh[2][7], sh[4][0], sample_i})
    end
    sample_i <= 11'h500;
    bus(1'b1, 1'b0, 8'h3d, 8'h20);
    rd(8'h3d, 8'h20);
    period(8'h08, 16);
    period(8'h88, 0);
    `CHK(corrected_o !== sample_i, 1'b1)
    give_verdict();
  end
endmodule
